// ### verilog/snce_engine.v
// Serial command engine of a byte-wide nonvolatile memory acting as SPI target.
`timescale 1ns/1ps
`include "snce_regs.vh"
module snce_engine #(
  parameter ADDR_W = 19,
  parameter DEPTH = 524288,
  parameter WAKE_CYC = `SNCE_WAKE_CYC,
  parameter [7:0] MAKER_ID = 8'h5a, // Arbitrary value.
  parameter [7:0] CONT_ID = 8'h7f, // Arbitrary value.
  parameter [7:0] PROD_ID1 = 8'h12, // Arbitrary value.
  parameter [7:0] PROD_ID2 = 8'h34 // Arbitrary value.
) (
  input wire core_clk,
  input wire arst_n,
  input wire cs_n,
  input wire sck,
  input wire si,
  input wire wp_n,
  input wire hold_n,
  output reg so_q,
  output reg so_oe_q,
  output reg asleep_q,
  output reg [7:0] status_q
);
  localparam ST_OP = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_DUMMY = 3'd2;
  localparam ST_RDATA = 3'd3;
  localparam ST_WDATA = 3'd4;
  localparam ST_STOUT = 3'd5;
  localparam ST_STIN = 3'd6;
  localparam ST_IDLE = 3'd7;

  wire cs_s;
  wire cs_rise;
  wire cs_fall;
  wire sck_rise;
  wire sck_fall;
  wire si_s;
  wire wp_s;
  wire hold_s;

  reg [2:0] state_q;
  reg [7:0] opcode_q;
  reg [4:0] bit_cnt_q;
  reg [23:0] shift_q;
  reg [ADDR_W-1:0] addr_q;
  reg [7:0] out_byte_q;
  reg [1:0] id_idx_q;
  reg id_done_q;
  reg is_fast_q;
  reg sleep_arm_q;
  reg wel_q;
  reg wel_shadow_q;
  reg hold_q;
  reg holding_q;
  reg [31:0] wake_cnt_q;
  reg [7:0] mem [0:DEPTH-1];
  reg [7:0] rd_data;
  reg [7:0] next_in;

  // Selected, awake, not paused: only then do clock edges count.
  wire active = !cs_s && !asleep_q && !holding_q;

  snce_sync #(.RST_VAL(1'b1)) u_cs (.core_clk(core_clk), .arst_n(arst_n), .din(cs_n),
    .level_q(cs_s), .rise(cs_rise), .fall(cs_fall));
  snce_sync #(.RST_VAL(1'b0)) u_sck (.core_clk(core_clk), .arst_n(arst_n), .din(sck),
    .level_q(), .rise(sck_rise), .fall(sck_fall));
  snce_sync #(.RST_VAL(1'b0)) u_si (.core_clk(core_clk), .arst_n(arst_n), .din(si),
    .level_q(si_s), .rise(), .fall());
  snce_sync #(.RST_VAL(1'b1)) u_wp (.core_clk(core_clk), .arst_n(arst_n), .din(wp_n),
    .level_q(wp_s), .rise(), .fall());
  snce_sync #(.RST_VAL(1'b1)) u_hold (.core_clk(core_clk), .arst_n(arst_n), .din(hold_n),
    .level_q(hold_s), .rise(), .fall());

  // Array address is protected when it lies in the range the protect bits pick.
  function addr_protected;
    input [1:0] bp;
    input [ADDR_W-1:0] a;
    begin
      case (bp)
        2'b00: addr_protected = 1'b0;
        2'b01: addr_protected = (a >= `SNCE_PROT_QTR);
        2'b10: addr_protected = (a >= `SNCE_PROT_HALF);
        default: addr_protected = 1'b1;
      endcase
    end
  endfunction

  // Next byte address, wrapping from the top of the array to zero.
  function [ADDR_W-1:0] addr_next;
    input [ADDR_W-1:0] a;
    begin
      addr_next = (a == DEPTH - 1) ? {ADDR_W{1'b0}} : a + 1'b1;
    end
  endfunction

  // Identification byte chosen by index, maker code first.
  function [7:0] id_byte;
    input [1:0] idx;
    begin
      case (idx)
        2'd0: id_byte = MAKER_ID;
        2'd1: id_byte = CONT_ID;
        2'd2: id_byte = PROD_ID1;
        default: id_byte = PROD_ID2;
      endcase
    end
  endfunction

  // Combinational array read and byte assembled from the incoming bit.
  always @* begin
    rd_data = mem[addr_q];
    next_in = {shift_q[6:0], si_s};
  end

  // Array writes commit a whole received byte when the latch and range allow.
  always @(posedge core_clk) begin
    if (state_q == ST_WDATA && active && sck_rise && bit_cnt_q == 5'd7 &&
        wel_q && !addr_protected(status_q[3:2], addr_q)) begin
      mem[addr_q] <= next_in;
    end
  end

  // Hold is taken only while selected; leaving select aborts it.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      holding_q <= 1'b0;
    end else begin
      holding_q <= !cs_s && !hold_s && !asleep_q;
    end
  end

  // Main command sequencer.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      opcode_q <= 8'h00;
      bit_cnt_q <= 5'd0;
      shift_q <= 24'h000000;
      addr_q <= {ADDR_W{1'b0}};
      out_byte_q <= 8'h00;
      id_idx_q <= 2'd0;
      id_done_q <= 1'b0;
      is_fast_q <= 1'b0;
      sleep_arm_q <= 1'b0;
      wel_q <= 1'b0;
      wel_shadow_q <= 1'b0;
      hold_q <= 1'b0;
      status_q <= `SNCE_ST_RESET;
      asleep_q <= 1'b0;
      wake_cnt_q <= 32'd0;
    end else begin
      status_q[`SNCE_ST_WEL] <= wel_q;
      status_q[0] <= 1'b0;
      hold_q <= holding_q;
      // Remember the latch when hold begins before an op-code is known.
      if (holding_q && !hold_q) begin
        wel_shadow_q <= wel_q;
      end
      if (asleep_q) begin
        // Wake counter runs from select falling; inputs are ignored meanwhile.
        if (cs_fall && wake_cnt_q == 32'd0) begin
          wake_cnt_q <= 32'd1;
        end else if (wake_cnt_q != 32'd0) begin
          if (wake_cnt_q >= WAKE_CYC) begin
            wake_cnt_q <= 32'd0;
            asleep_q <= 1'b0;
          end else begin
            wake_cnt_q <= wake_cnt_q + 32'd1;
          end
        end
        state_q <= ST_IDLE;
      end else if (cs_s) begin
        // Deselect aborts any command; partial op-codes are lost.
        if (cs_rise && sleep_arm_q && !holding_q) begin
          asleep_q <= 1'b1;
        end
        if (cs_rise && hold_q && state_q == ST_OP) begin
          wel_q <= wel_shadow_q;
        end
        state_q <= ST_IDLE;
        sleep_arm_q <= 1'b0;
        id_done_q <= 1'b0;
      end else if (state_q == ST_IDLE) begin
        state_q <= ST_OP;
        bit_cnt_q <= 5'd0;
      end else if (active && sck_rise) begin
        // Inputs sampled on rising clock edges, both modes.
        shift_q <= {shift_q[22:0], si_s};
        bit_cnt_q <= bit_cnt_q + 5'd1;
        sleep_arm_q <= 1'b0;
        case (state_q)
          ST_OP: begin
            if (bit_cnt_q == 5'd7) begin
              opcode_q <= next_in;
              bit_cnt_q <= 5'd0;
              is_fast_q <= (next_in == `SNCE_OP_FAST);
              case (next_in)
                `SNCE_OP_SET_WEL: wel_q <= 1'b1;
                `SNCE_OP_CLR_WEL: wel_q <= 1'b0;
                `SNCE_OP_RD_STAT: state_q <= ST_STOUT;
                `SNCE_OP_WR_STAT: state_q <= ST_STIN;
                `SNCE_OP_READ: state_q <= ST_ADDR;
                `SNCE_OP_FAST: state_q <= ST_ADDR;
                `SNCE_OP_WRITE: state_q <= ST_ADDR;
                `SNCE_OP_ID: begin
                  state_q <= ST_RDATA;
                  id_idx_q <= 2'd0;
                end
                `SNCE_OP_SLEEP: sleep_arm_q <= 1'b1;
                default: state_q <= ST_IDLE;
              endcase
              if (next_in != `SNCE_OP_RD_STAT && next_in != `SNCE_OP_WR_STAT &&
                  next_in != `SNCE_OP_READ && next_in != `SNCE_OP_FAST &&
                  next_in != `SNCE_OP_WRITE && next_in != `SNCE_OP_ID) begin
                state_q <= ST_IDLE;
              end
              // Preload the first output byte for status and id reads.
              out_byte_q <= (next_in == `SNCE_OP_ID) ? id_byte(2'd0) : status_q;
            end
          end
          ST_ADDR: begin
            if (bit_cnt_q == 5'd23) begin
              addr_q <= {shift_q[ADDR_W-2:0], si_s};
              bit_cnt_q <= 5'd0;
              if (opcode_q == `SNCE_OP_WRITE) begin
                state_q <= ST_WDATA;
              end else if (is_fast_q) begin
                state_q <= ST_DUMMY;
              end else begin
                state_q <= ST_RDATA;
              end
            end
          end
          ST_DUMMY: begin
            if (bit_cnt_q == 5'd7) begin
              bit_cnt_q <= 5'd0;
              state_q <= ST_RDATA;
            end
          end
          ST_WDATA: begin
            if (bit_cnt_q == 5'd7) begin
              bit_cnt_q <= 5'd0;
              addr_q <= addr_next(addr_q);
            end
          end
          ST_STIN: begin
            if (bit_cnt_q == 5'd7) begin
              bit_cnt_q <= 5'd0;
              if (wel_q && !(status_q[`SNCE_ST_LOCK] && !wp_s)) begin
                status_q[7:2] <= next_in[7:2];
              end
              state_q <= ST_IDLE;
            end
          end
          default: begin
            // Reads count bits only; data in is ignored.
            if (bit_cnt_q == 5'd7) begin
              bit_cnt_q <= 5'd0;
            end
          end
        endcase
      end else if (active && sck_fall) begin
        // Output bytes advance on falling edges; a finished id freezes the last bit.
        if ((state_q == ST_RDATA || state_q == ST_STOUT) &&
            !(opcode_q == `SNCE_OP_ID && id_done_q)) begin
          if (bit_cnt_q == 5'd0) begin
            if (opcode_q == `SNCE_OP_ID) begin
              out_byte_q <= id_byte(id_idx_q);
            end else if (state_q == ST_STOUT) begin
              out_byte_q <= status_q;
            end else begin
              out_byte_q <= rd_data;
              addr_q <= addr_next(addr_q);
            end
          end else begin
            out_byte_q <= {out_byte_q[6:0], 1'b0};
          end
          if (opcode_q == `SNCE_OP_ID && bit_cnt_q == 5'd7) begin
            if (id_idx_q == 2'd3) begin
              id_done_q <= 1'b1;
            end else begin
              id_idx_q <= id_idx_q + 2'd1;
            end
          end
        end
      end
    end
  end

  // Output pin driver; floats when deselected, asleep, paused or idle.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      so_oe_q <= !cs_s && !asleep_q && !holding_q &&
                 (state_q == ST_RDATA || state_q == ST_STOUT);
      so_q <= out_byte_q[7];
    end
  end
endmodule // snce_engine

// ### verilog/snce_regs.vh
// Constants for the serial nonvolatile memory command engine.
`ifndef SNCE_REGS_VH
`define SNCE_REGS_VH
`define SNCE_OP_SET_WEL 8'h06
`define SNCE_OP_CLR_WEL 8'h04
`define SNCE_OP_RD_STAT 8'h05
`define SNCE_OP_WR_STAT 8'h01
`define SNCE_OP_READ 8'h03
`define SNCE_OP_WRITE 8'h02
`define SNCE_OP_ID 8'h9f
`define SNCE_OP_FAST 8'h0b
`define SNCE_OP_SLEEP 8'hb9
`define SNCE_ST_LOCK 7
`define SNCE_ST_BP_HI 3
`define SNCE_ST_BP_LO 2
`define SNCE_ST_WEL 1
`define SNCE_ST_RESET 8'h00
`define SNCE_PROT_QTR 19'h60000
`define SNCE_PROT_HALF 19'h40000
`define SNCE_WAKE_US 400
`define SNCE_CLK_MHZ 250
`define SNCE_WAKE_CYC (`SNCE_WAKE_US * `SNCE_CLK_MHZ)
`endif

// ### verilog/snce_sync.v
// Two-flop synchroniser with edge detection on the synchronised level.
`timescale 1ns/1ps
module snce_sync #(
  parameter RST_VAL = 1'b0
) (
  input wire core_clk,
  input wire arst_n,
  input wire din,
  output reg level_q,
  output wire rise,
  output wire fall
);
  reg meta_q;
  reg prev_q;

  // The first flop feeds only the second flop.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= RST_VAL;
      level_q <= RST_VAL;
      prev_q <= RST_VAL;
    end else begin
      meta_q <= din;
      level_q <= meta_q;
      prev_q <= level_q;
    end
  end

  // Edges are found on the settled copies only.
  assign rise = level_q & ~prev_q;
  assign fall = ~level_q & prev_q;
endmodule // snce_sync

// ### testbench/snce_chk.sv
// Pin-level assertions for the serial command engine.
`timescale 1ns/1ps
module snce_chk #(
  parameter WAKE_CYC = 50
) (
  input wire core_clk,
  input wire arst_n,
  input wire cs_n,
  input wire sck,
  input wire si,
  input wire wp_n,
  input wire hold_n,
  input wire so_q,
  input wire so_oe_q,
  input wire asleep_q,
  input wire [7:0] status_q
);
  reg [31:0] wake_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Counts asleep cycles from the select fall, even if select rises early.
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_q <= 32'h0;
    end else if (!asleep_q) begin
      wake_q <= 32'h0;
    end else if (!cs_n || wake_q != 32'h0) begin
      wake_q <= wake_q + 32'h1;
    end
  end
  a_desel_float: assert property (cs_n [*5] |-> !so_oe_q)
    else $error("so on while deselected");
  a_sleep_float: assert property (asleep_q |-> !so_oe_q)
    else $error("so on while asleep");
  a_hold_float: assert property ((!hold_n && !cs_n) [*5] |-> !so_oe_q)
    else $error("so on during hold");
  a_zero_bit: assert property (status_q[0] == 1'b0)
    else $error("status bit 0 set");
  a_so_steady: assert property ((sck && so_oe_q) [*6] |-> $stable(so_q))
    else $error("so moved with clock high");
  a_sleep_desel: assert property ($rose(asleep_q) |-> cs_n)
    else $error("sleep while selected");
  a_wake_bound: assert property (wake_q <= WAKE_CYC + 8)
    else $error("wake too slow");
  a_lock_keep: assert property ((status_q[7] && !wp_n) [*4] |-> $stable(status_q[7:2]))
    else $error("locked status changed");
  a_wel_guard: assert property ($changed(status_q[7:2]) |-> $past(status_q[1]))
    else $error("status changed with latch clear");
  c_sleep: cover property ($rose(asleep_q));
  c_read: cover property ($rose(so_oe_q));
  c_hold: cover property (!hold_n && !cs_n);
endmodule // snce_chk
bind snce_engine snce_chk #(.WAKE_CYC(WAKE_CYC)) snce_chk_i (.core_clk(core_clk),
  .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .hold_n(hold_n),
  .so_q(so_q), .so_oe_q(so_oe_q), .asleep_q(asleep_q), .status_q(status_q));

// ### testbench/snce_host.sv
// SPI host model driving select, clock and data of the engine.
`timescale 1ns/1ps
module snce_host (
  input wire core_clk,
  input wire so_q,
  input wire so_oe_q,
  output reg cs_n,
  output reg sck,
  output reg si,
  output reg hold_n
);
  reg cpol;
  // Pins start deselected with hold released.
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    cpol = 1'b0;
  end
  // Ten core clocks make half of the 80 ns link period.
  task tick(input integer n);
    begin
      repeat (n) @(posedge core_clk);
    end
  endtask
  // Parks the clock at the mode's idle level, then selects.
  task sel(input m3);
    begin
      cpol = m3;
      sck <= m3;
      tick(4);
      cs_n <= 1'b0;
      tick(10);
    end
  endtask
  // One bit: data set while low, reply sampled just before the rise.
  task xbit(input d, output q);
    begin
      si <= d;
      if (cpol) begin
        sck <= 1'b0;
      end
      tick(10);
      q = so_oe_q ? so_q : 1'bx;
      sck <= 1'b1;
      tick(10);
      if (!cpol) begin
        sck <= 1'b0;
      end
    end
  endtask
  // One byte, most significant bit first.
  task xb(input [7:0] d, output [7:0] q);
    integer k;
    begin
      for (k = 7; k >= 0; k = k - 1) begin
        xbit(d[k], q[k]);
      end
    end
  endtask
  // Drives the hold pin; the caller keeps the clock level across the pause.
  task hold_set(input h);
    begin
      hold_n <= h;
    end
  endtask
  // Ends the frame with the clock at rest.
  task desel;
    begin
      tick(10);
      cs_n <= 1'b1;
      tick(12);
    end
  endtask
endmodule // snce_host

// ### testbench/test_serial_nv_memory_command_engine.sv
// Self-checking bench for the serial command engine.
`timescale 1ns/1ps
module test_serial_nv_memory_command_engine;
  reg core_clk;
  reg arst_n;
  reg wp_n;
  wire cs_n, sck, si, hold_n, so_q, so_oe_q, asleep_q;
  wire [7:0] status_q;
  integer err_total, tests_run, i;
  reg [7:0] r;
  reg [39:0] idv;
  // Short wake count; identity bytes are arbitrary values.
  snce_engine #(.WAKE_CYC(50), .MAKER_ID(8'h5a), .CONT_ID(8'h6c), .PROD_ID1(8'h12),
    .PROD_ID2(8'h35)) snce_engine_i (.core_clk(core_clk), .arst_n(arst_n), .cs_n(cs_n),
    .sck(sck), .si(si), .wp_n(wp_n), .hold_n(hold_n), .so_q(so_q), .so_oe_q(so_oe_q),
    .asleep_q(asleep_q), .status_q(status_q));
  snce_host snce_host_i (.core_clk(core_clk), .so_q(so_q), .so_oe_q(so_oe_q),
    .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));
  // Counts a comparison and reports a mismatch.
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  task cmd(input [7:0] op);
    begin
      snce_host_i.sel(1'b0);
      snce_host_i.xb(op, r);
      snce_host_i.desel;
    end
  endtask
  // Two status bytes in one frame.
  task stat(input m3, input [7:0] exp);
    begin
      snce_host_i.sel(m3);
      snce_host_i.xb(8'h05, r);
      snce_host_i.xb(8'h55, r);
      chk(r, exp);
      snce_host_i.xb(8'haa, r);
      chk(r, exp);
      snce_host_i.desel;
    end
  endtask
  // Op-code and address, the ignored top bits set to ones.
  task mop(input [7:0] op, input [18:0] a);
    begin
      snce_host_i.sel(1'b0);
      snce_host_i.xb(op, r);
      snce_host_i.xb({5'h1f, a[18:16]}, r);
      snce_host_i.xb(a[15:8], r);
      snce_host_i.xb(a[7:0], r);
    end
  endtask
  task wr(input [18:0] a, input [7:0] d0, input [7:0] d1);
    begin
      mop(8'h02, a);
      snce_host_i.xb(d0, r);
      snce_host_i.xb(d1, r);
      snce_host_i.desel;
    end
  endtask
  task rd(input [7:0] op, input [18:0] a, input [7:0] e0, input [7:0] e1);
    begin
      mop(op, a);
      if (op == 8'h0b) begin
        snce_host_i.xb(8'h5a, r);
      end
      snce_host_i.xb(8'h55, r);
      chk(r, e0);
      snce_host_i.xb(8'haa, r);
      chk(r, e1);
      snce_host_i.desel;
    end
  endtask
  task ws(input [7:0] d);
    begin
      snce_host_i.sel(1'b0);
      snce_host_i.xb(8'h01, r);
      snce_host_i.xb(d, r);
      snce_host_i.desel;
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // A hang counts as a mismatch.
  initial begin
    #360000;
    err_total = err_total + 1;
    end_sim;
  end
  // Main sequence.
  initial begin
    arst_n = 1'b0;
    wp_n = 1'b1;
    err_total = 0;
    tests_run = 0;
    idv = 40'h5a6c1235ff;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    snce_host_i.tick(4);
    chk({so_oe_q, asleep_q, status_q}, 10'h000);
    cmd(8'h06);
    stat(1'b0, 8'h02);
    wr(19'h7ffff, 8'ha5, 8'h3c);
    wr(19'h5ffff, 8'h22, 8'h11);
    rd(8'h03, 19'h7ffff, 8'ha5, 8'h3c);
    rd(8'h0b, 19'h5ffff, 8'h22, 8'h11);
    snce_host_i.sel(1'b0);
    for (i = 0; i < 7; i = i + 1) begin
      snce_host_i.xbit(i == 5, r[0]);
    end
    snce_host_i.desel;
    stat(1'b0, 8'h02);
    cmd(8'h04);
    stat(1'b0, 8'h00);
    wr(19'h7ffff, 8'h00, 8'h00);
    rd(8'h03, 19'h7ffff, 8'ha5, 8'h3c);
    cmd(8'h06);
    ws(8'hff);
    stat(1'b0, 8'hfe);
    wp_n <= 1'b0;
    ws(8'h00);
    stat(1'b0, 8'hfe);
    wp_n <= 1'b1;
    ws(8'h04);
    stat(1'b1, 8'h06);
    wr(19'h5ffff, 8'h77, 8'h88);
    rd(8'h03, 19'h5ffff, 8'h77, 8'h11);
    ws(8'h08);
    wr(19'h7ffff, 8'h44, 8'h55);
    rd(8'h03, 19'h7ffff, 8'ha5, 8'h55);
    ws(8'h0c);
    wr(19'h7ffff, 8'h66, 8'h77);
    rd(8'h03, 19'h7ffff, 8'ha5, 8'h55);
    ws(8'h00);
    snce_host_i.sel(1'b0);
    snce_host_i.xb(8'h9f, r);
    for (i = 0; i < 5; i = i + 1) begin
      snce_host_i.xb(8'h55, r);
      chk(r, idv[39 - 8 * i -: 8]);
    end
    snce_host_i.desel;
    snce_host_i.sel(1'b0);
    snce_host_i.xb(8'h05, r);
    for (i = 0; i < 8; i = i + 1) begin
      if (i == 4) begin
        snce_host_i.tick(5);
        snce_host_i.hold_set(1'b0);
        snce_host_i.tick(10);
        chk(so_oe_q, 1'b0);
        snce_host_i.hold_set(1'b1);
        snce_host_i.tick(10);
      end
      snce_host_i.xbit(1'b0, r[7 - i]);
    end
    chk(r, 8'h02);
    snce_host_i.desel;
    snce_host_i.sel(1'b0);
    snce_host_i.xb(8'hb9, r);
    snce_host_i.xbit(1'b0, r[0]);
    snce_host_i.desel;
    chk(asleep_q, 1'b0);
    cmd(8'hb9);
    chk({asleep_q, so_oe_q}, 2'b10);
    snce_host_i.sel(1'b0);
    for (i = 0; i < 80 && asleep_q !== 1'b0; i = i + 1) begin
      snce_host_i.tick(1);
    end
    chk(asleep_q, 1'b0);
    if (asleep_q !== 1'b0) begin
      end_sim;
    end
    snce_host_i.desel;
    stat(1'b0, 8'h02);
    end_sim;
  end
endmodule // test_serial_nv_memory_command_engine
